// *** design/pinroute_pkg.sv ***
// Constants and carrier types for the serial pin routing setup controller.
// Assumes one 100 MHz clock and a device reached by a plain register write port.
package pinroute_pkg;

	//////////////////////////////////////////////////////////////////////////////
	// Controller registers on the AHB-Lite bus, byte addresses.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PORTS = 8'h08;
	localparam int CTRL_PROFILE_LSB = 0;
	localparam int CTRL_GO_BIT = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_ERROR_BIT = 2;
	localparam int STAT_ENABLE_LSB = 4;
	localparam int PORTS_LATCH_LSB = 8;
	localparam logic [3:0] CTRL_PROFILE_RESET = 4'h0;

	//////////////////////////////////////////////////////////////////////////////
	// Setup profiles that software may request.
	localparam logic [3:0] PROF_STOP_ALL = 4'h0;
	localparam logic [3:0] PROF_CSI = 4'h1;
	localparam logic [3:0] PROF_LINK_B = 4'h2;
	localparam logic [3:0] PROF_IIC_START = 4'h3;
	localparam logic [3:0] PROF_IIC_ADDR = 4'h4;
	localparam logic [3:0] PROF_IIC_STOP = 4'h5;
	localparam logic [3:0] PROF_LINK_C = 4'h6;

	//////////////////////////////////////////////////////////////////////////////
	// Device register indices and field positions.
	localparam logic [7:0] DEV_STOP_TRIG = 8'h01;
	localparam logic [7:0] DEV_START_TRIG = 8'h02;
	localparam logic [7:0] DEV_MODE_CH0 = 8'h10;
	localparam logic [7:0] DEV_MODE_CH1 = 8'h11;
	localparam logic [7:0] DEV_MODE_CH2 = 8'h12;
	localparam logic [7:0] DEV_MODE_CH3 = 8'h13;
	localparam logic [7:0] DEV_CTRL_CH0 = 8'h20;
	localparam logic [7:0] DEV_CTRL_CH1 = 8'h21;
	localparam logic [7:0] DEV_CTRL_CH2 = 8'h22;
	localparam logic [7:0] DEV_CTRL_CH3 = 8'h23;
	localparam logic [7:0] DEV_PORT_DIR = 8'h30;
	localparam logic [7:0] DEV_PORT_LATCH = 8'h31;
	localparam logic [15:0] MODE_CLOCKED = 16'h0000;
	localparam logic [15:0] MODE_ASYNC = 16'h0001;
	localparam logic [15:0] MODE_TWOWIRE = 16'h0002;
	localparam logic [15:0] CH_TX = 16'h0001;
	localparam logic [15:0] CH_RX = 16'h0002;
	localparam logic [15:0] CH_OE = 16'h0004;
	localparam logic [15:0] CH_SO = 16'h0008;
	localparam logic [15:0] CH_CKO = 16'h0010;
	localparam logic [15:0] PIN_CLK = 16'h0001;
	localparam logic [15:0] PIN_DIN = 16'h0002;
	localparam logic [15:0] PIN_DOUT = 16'h0004;
	localparam logic [15:0] PIN_CTX = 16'h0008;
	localparam logic [15:0] PIN_CRX = 16'h0010;
	localparam logic [15:0] DIR_RESET = 16'h001f;
	localparam logic [15:0] LATCH_RESET = 16'h0000;
	localparam logic [15:0] ALL_BITS = 16'hffff;
	localparam logic [15:0] CH_B_PAIR = 16'h0003;
	localparam logic [15:0] CH_C_PAIR = 16'h000c;
	localparam logic [15:0] CH_ALL = 16'h000f;
	localparam logic [15:0] CH_0 = 16'h0001;

	//////////////////////////////////////////////////////////////////////////////
	// Carrier types.
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] data;
	} dev_wr_t;

	typedef struct packed {
		logic used;
		logic last;
		logic [7:0] addr;
		logic [15:0] data;
		logic [15:0] mask;
	} step_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_DRAIN
	} seq_state_t;

endpackage

// *** design/dev_write_port.sv ***
// Holds one device register write until the device takes it.
// Assumes the device raises ready for the cycle in which it takes a write.
`timescale 1ns/1ps
module dev_write_port (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Request side.
	input wire logic in_valid,
	output logic in_ready,
	input pinroute_pkg::dev_wr_t in_wr,
	// Device side.
	output logic dev_wr_valid,
	output pinroute_pkg::dev_wr_t dev_wr,
	input wire logic dev_wr_ready
);

	logic valid_ff;
	logic nxt_valid;
	pinroute_pkg::dev_wr_t wr_ff;
	pinroute_pkg::dev_wr_t nxt_wr;

	assign in_ready = !valid_ff;
	assign dev_wr_valid = valid_ff;
	assign dev_wr = wr_ff;

	always_comb begin
		nxt_valid = valid_ff;
		nxt_wr = wr_ff;
		if (valid_ff && dev_wr_ready) begin
			nxt_valid = 1'b0;
		end
		if (in_valid && !valid_ff) begin
			nxt_valid = 1'b1;
			nxt_wr = in_wr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			valid_ff <= 1'b0;
			wr_ff <= '0;
		end else begin
			valid_ff <= nxt_valid;
			wr_ff <= nxt_wr;
		end
	end

endmodule // dev_write_port

// *** design/serial_pin_setup_host.sv ***
// Setup controller that drives the serial unit's channel and pin settings.
// Assumes an AHB-Lite master for software and a device register write port.
//
// How it works
// - Async receive on ch1 keeps ch0 stopped/transmitting.
// - Clocked or two-wire ch0 keeps ch1 stopped (the address-send profile writes no stop for ch1).
// - Paired link: ch0 transmits, ch1 receives.
// - Ch1 reception also programs ch0 mode.
// - Start: clock level 1, then data 1 to 0.
// - Stop: clock level 1, then data 0 to 1.
// - Address send: fixed enables, pins direction 0, latch 1.
// - Ch2 transmit: tx 1, rx 0, pin out high.
// - Second link: ch2 transmits, ch3 receives.
// - Ch3 reception keeps ch2 stopped/transmitting.
// - Ch3 reception also programs ch2 mode.
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module serial_pin_setup_host #(
	parameter int MAX_STEPS = 8
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Device register write port.
	output logic dev_wr_valid,
	output pinroute_pkg::dev_wr_t dev_wr,
	input wire logic dev_wr_ready,
	// Device channel enable status.
	input wire logic [3:0] unit_channel_enable_status
);

	if (MAX_STEPS != 8) begin : g_steps_check
		$error("MAX_STEPS must be 8 for the three-bit step index.");
	end

	//////////////////////////////////////////////////////////////////////////////
	// Step table.

	function automatic pinroute_pkg::step_t mk(input logic [7:0] a, input logic [15:0] d,
		input logic [15:0] m, input logic l);
		pinroute_pkg::step_t s;
		s.used = 1'b1;
		s.last = l;
		s.addr = a;
		s.data = d;
		s.mask = m;
		return s;
	endfunction

	function automatic pinroute_pkg::step_t seq_step(input logic [3:0] prof, input logic [2:0] i);
		pinroute_pkg::step_t s;
		s = '0;
		case (prof)
			pinroute_pkg::PROF_STOP_ALL: begin
				s = mk(pinroute_pkg::DEV_STOP_TRIG, pinroute_pkg::CH_ALL, pinroute_pkg::ALL_BITS,
					1'b1);
			end
			pinroute_pkg::PROF_CSI: begin
				case (i)
					3'h0: s = mk(pinroute_pkg::DEV_STOP_TRIG, pinroute_pkg::CH_B_PAIR,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h1: s = mk(pinroute_pkg::DEV_MODE_CH0, pinroute_pkg::MODE_CLOCKED,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h2: s = mk(pinroute_pkg::DEV_CTRL_CH0, pinroute_pkg::CH_TX | pinroute_pkg::CH_RX
						| pinroute_pkg::CH_OE | pinroute_pkg::CH_SO | pinroute_pkg::CH_CKO,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h3: s = mk(pinroute_pkg::DEV_PORT_DIR, pinroute_pkg::PIN_DIN,
						pinroute_pkg::PIN_CLK | pinroute_pkg::PIN_DIN | pinroute_pkg::PIN_DOUT, 1'b0);
					3'h4: s = mk(pinroute_pkg::DEV_PORT_LATCH, pinroute_pkg::PIN_CLK
						| pinroute_pkg::PIN_DOUT, pinroute_pkg::PIN_CLK | pinroute_pkg::PIN_DOUT, 1'b0);
					3'h5: s = mk(pinroute_pkg::DEV_START_TRIG, pinroute_pkg::CH_0,
						pinroute_pkg::ALL_BITS, 1'b1);
					default: s = '0;
				endcase
			end
			pinroute_pkg::PROF_LINK_B: begin
				case (i)
					3'h0: s = mk(pinroute_pkg::DEV_STOP_TRIG, pinroute_pkg::CH_B_PAIR,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h1: s = mk(pinroute_pkg::DEV_MODE_CH0, pinroute_pkg::MODE_ASYNC,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h2: s = mk(pinroute_pkg::DEV_MODE_CH1, pinroute_pkg::MODE_ASYNC,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h3: s = mk(pinroute_pkg::DEV_CTRL_CH0, pinroute_pkg::CH_TX | pinroute_pkg::CH_OE
						| pinroute_pkg::CH_SO | pinroute_pkg::CH_CKO,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h4: s = mk(pinroute_pkg::DEV_CTRL_CH1, pinroute_pkg::CH_RX,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h5: s = mk(pinroute_pkg::DEV_PORT_DIR, pinroute_pkg::PIN_DIN,
						pinroute_pkg::PIN_DIN | pinroute_pkg::PIN_DOUT, 1'b0);
					3'h6: s = mk(pinroute_pkg::DEV_PORT_LATCH, pinroute_pkg::PIN_DOUT,
						pinroute_pkg::PIN_DOUT, 1'b0);
					3'h7: s = mk(pinroute_pkg::DEV_START_TRIG, pinroute_pkg::CH_B_PAIR,
						pinroute_pkg::ALL_BITS, 1'b1);
					default: s = '0;
				endcase
			end
			pinroute_pkg::PROF_IIC_START: begin
				case (i)
					3'h0: s = mk(pinroute_pkg::DEV_STOP_TRIG, pinroute_pkg::CH_B_PAIR,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h1: s = mk(pinroute_pkg::DEV_MODE_CH0, pinroute_pkg::MODE_TWOWIRE,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h2: s = mk(pinroute_pkg::DEV_PORT_DIR, '0,
						pinroute_pkg::PIN_CLK | pinroute_pkg::PIN_DIN, 1'b0);
					3'h3: s = mk(pinroute_pkg::DEV_PORT_LATCH, pinroute_pkg::PIN_CLK
						| pinroute_pkg::PIN_DIN, pinroute_pkg::PIN_CLK | pinroute_pkg::PIN_DIN, 1'b0);
					3'h4: s = mk(pinroute_pkg::DEV_CTRL_CH0, pinroute_pkg::CH_CKO | pinroute_pkg::CH_SO,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h5: s = mk(pinroute_pkg::DEV_CTRL_CH0, pinroute_pkg::CH_CKO,
						pinroute_pkg::ALL_BITS, 1'b1);
					default: s = '0;
				endcase
			end
			pinroute_pkg::PROF_IIC_ADDR: begin
				case (i)
					3'h0: s = mk(pinroute_pkg::DEV_MODE_CH0, pinroute_pkg::MODE_TWOWIRE,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h1: s = mk(pinroute_pkg::DEV_PORT_DIR, '0,
						pinroute_pkg::PIN_CLK | pinroute_pkg::PIN_DIN, 1'b0);
					3'h2: s = mk(pinroute_pkg::DEV_PORT_LATCH, pinroute_pkg::PIN_CLK
						| pinroute_pkg::PIN_DIN, pinroute_pkg::PIN_CLK | pinroute_pkg::PIN_DIN,
						1'b0);
					3'h3: s = mk(pinroute_pkg::DEV_CTRL_CH0, pinroute_pkg::CH_TX | pinroute_pkg::CH_OE
						| pinroute_pkg::CH_CKO, pinroute_pkg::ALL_BITS, 1'b0);
					3'h4: s = mk(pinroute_pkg::DEV_START_TRIG, pinroute_pkg::CH_0,
						pinroute_pkg::ALL_BITS, 1'b1);
					default: s = '0;
				endcase
			end
			pinroute_pkg::PROF_IIC_STOP: begin
				case (i)
					3'h0: s = mk(pinroute_pkg::DEV_STOP_TRIG, pinroute_pkg::CH_0,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h1: s = mk(pinroute_pkg::DEV_CTRL_CH0, pinroute_pkg::CH_CKO,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h2: s = mk(pinroute_pkg::DEV_CTRL_CH0, pinroute_pkg::CH_CKO | pinroute_pkg::CH_SO,
						pinroute_pkg::ALL_BITS, 1'b1);
					default: s = '0;
				endcase
			end
			pinroute_pkg::PROF_LINK_C: begin
				case (i)
					3'h0: s = mk(pinroute_pkg::DEV_STOP_TRIG, pinroute_pkg::CH_C_PAIR,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h1: s = mk(pinroute_pkg::DEV_MODE_CH2, pinroute_pkg::MODE_ASYNC,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h2: s = mk(pinroute_pkg::DEV_MODE_CH3, pinroute_pkg::MODE_ASYNC,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h3: s = mk(pinroute_pkg::DEV_CTRL_CH2, pinroute_pkg::CH_TX | pinroute_pkg::CH_OE
						| pinroute_pkg::CH_SO, pinroute_pkg::ALL_BITS, 1'b0);
					3'h4: s = mk(pinroute_pkg::DEV_CTRL_CH3, pinroute_pkg::CH_RX,
						pinroute_pkg::ALL_BITS, 1'b0);
					3'h5: s = mk(pinroute_pkg::DEV_PORT_DIR, pinroute_pkg::PIN_CRX,
						pinroute_pkg::PIN_CTX | pinroute_pkg::PIN_CRX, 1'b0);
					3'h6: s = mk(pinroute_pkg::DEV_PORT_LATCH, pinroute_pkg::PIN_CTX,
						pinroute_pkg::PIN_CTX, 1'b0);
					3'h7: s = mk(pinroute_pkg::DEV_START_TRIG, pinroute_pkg::CH_C_PAIR,
						pinroute_pkg::ALL_BITS, 1'b1);
					default: s = '0;
				endcase
			end
			default: s = '0;
		endcase
		return s;
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// Bus slave.

	logic wr_pend_ff;
	logic nxt_wr_pend;
	logic [7:0] wr_addr_ff;
	logic [7:0] nxt_wr_addr;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [3:0] profile_ff;
	logic [3:0] nxt_profile;
	logic done_ff;
	logic nxt_done;
	logic error_ff;
	logic nxt_error;
	logic [15:0] dir_ff;
	logic [15:0] nxt_dir;
	logic [15:0] latch_ff;
	logic [15:0] nxt_latch;
	pinroute_pkg::seq_state_t state_ff;
	pinroute_pkg::seq_state_t nxt_state;
	logic [2:0] idx_ff;
	logic [2:0] nxt_idx;
	logic addr_phase;
	logic go_write;
	logic busy;
	logic set_done;
	logic set_error;
	logic port_valid;
	logic port_ready;
	pinroute_pkg::step_t cur;
	pinroute_pkg::step_t go_step;
	pinroute_pkg::dev_wr_t port_wr;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_ff;
	assign addr_phase = hsel && hready && htrans[1];
	localparam int CTRL_GO = pinroute_pkg::CTRL_GO_BIT;

	assign busy = (state_ff != pinroute_pkg::ST_IDLE);
	assign go_write = wr_pend_ff && (wr_addr_ff == pinroute_pkg::REG_CTRL) && hwdata[CTRL_GO];

	always_comb begin
		nxt_wr_pend = addr_phase && hwrite;
		nxt_wr_addr = addr_phase ? {haddr[7:2], 2'b00} : wr_addr_ff;
		nxt_rdata = rdata_ff;
		nxt_profile = profile_ff;
		nxt_done = done_ff;
		nxt_error = error_ff;
		if (addr_phase && !hwrite) begin
			case ({haddr[7:2], 2'b00})
				pinroute_pkg::REG_CTRL: nxt_rdata = {28'h0000000, profile_ff};
				pinroute_pkg::REG_STATUS: nxt_rdata = {24'h000000, unit_channel_enable_status,
					1'b0, error_ff, done_ff, busy};
				pinroute_pkg::REG_PORTS: nxt_rdata = {latch_ff, dir_ff};
				default: nxt_rdata = 32'h00000000;
			endcase
		end
		if (wr_pend_ff && !busy && wr_addr_ff == pinroute_pkg::REG_CTRL) begin
			nxt_profile = hwdata[3:0];
		end
		if (wr_pend_ff && wr_addr_ff == pinroute_pkg::REG_STATUS) begin
			if (hwdata[pinroute_pkg::STAT_DONE_BIT]) begin
				nxt_done = 1'b0;
			end
			if (hwdata[pinroute_pkg::STAT_ERROR_BIT]) begin
				nxt_error = 1'b0;
			end
		end
		if (set_done) begin
			nxt_done = 1'b1;
		end
		if (set_error) begin
			nxt_error = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			rdata_ff <= 32'h00000000;
			profile_ff <= pinroute_pkg::CTRL_PROFILE_RESET;
			done_ff <= 1'b0;
			error_ff <= 1'b0;
		end else begin
			wr_pend_ff <= nxt_wr_pend;
			wr_addr_ff <= nxt_wr_addr;
			rdata_ff <= nxt_rdata;
			profile_ff <= nxt_profile;
			done_ff <= nxt_done;
			error_ff <= nxt_error;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Write sequencer.

	always_comb begin
		cur = seq_step(profile_ff, idx_ff);
		go_step = seq_step(hwdata[3:0], 3'h0);
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		nxt_dir = dir_ff;
		nxt_latch = latch_ff;
		set_done = 1'b0;
		set_error = 1'b0;
		port_valid = 1'b0;
		port_wr.addr = cur.addr;
		port_wr.data = cur.data;
		if (cur.addr == pinroute_pkg::DEV_PORT_DIR) begin
			port_wr.data = (dir_ff & ~cur.mask) | (cur.data & cur.mask);
		end
		if (cur.addr == pinroute_pkg::DEV_PORT_LATCH) begin
			port_wr.data = (latch_ff & ~cur.mask) | (cur.data & cur.mask);
		end
		case (state_ff)
			pinroute_pkg::ST_IDLE: begin
				if (go_write) begin
					if (go_step.used) begin
						nxt_state = pinroute_pkg::ST_RUN;
						nxt_idx = 3'h0;
					end else begin
						set_error = 1'b1;
					end
				end
			end
			pinroute_pkg::ST_RUN: begin
				port_valid = 1'b1;
				if (port_ready) begin
					if (cur.addr == pinroute_pkg::DEV_PORT_DIR) begin
						nxt_dir = port_wr.data;
					end
					if (cur.addr == pinroute_pkg::DEV_PORT_LATCH) begin
						nxt_latch = port_wr.data;
					end
					if (cur.last) begin
						nxt_state = pinroute_pkg::ST_DRAIN;
					end else begin
						nxt_idx = idx_ff + 3'h1;
					end
				end
			end
			pinroute_pkg::ST_DRAIN: begin
				if (port_ready) begin
					nxt_state = pinroute_pkg::ST_IDLE;
					set_done = 1'b1;
				end
			end
			default: nxt_state = pinroute_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= pinroute_pkg::ST_IDLE;
			idx_ff <= 3'h0;
			dir_ff <= pinroute_pkg::DIR_RESET;
			latch_ff <= pinroute_pkg::LATCH_RESET;
		end else begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
			dir_ff <= nxt_dir;
			latch_ff <= nxt_latch;
		end
	end

	dev_write_port u_port (
		.hclk(hclk),
		.hresetn(hresetn),
		.in_valid(port_valid),
		.in_ready(port_ready),
		.in_wr(port_wr),
		.dev_wr_valid(dev_wr_valid),
		.dev_wr(dev_wr),
		.dev_wr_ready(dev_wr_ready)
	);

endmodule // serial_pin_setup_host

// *** tb/serial_pin_setup_assertions.sv ***
// Checker for the serial pin setup controller, watching only its ports.
// Assumes it is bound to serial_pin_setup_host and that one clock serves everything.
`timescale 1ns/1ps
module serial_pin_setup_checker #(
	parameter int MAX_STEPS = 8
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Bus answer.
	input wire logic hreadyout,
	input wire logic hresp,
	// Device write port.
	input wire logic dev_wr_valid,
	input wire pinroute_pkg::dev_wr_t dev_wr,
	input wire logic dev_wr_ready
);
	logic taken;
	logic [7:0] a;
	logic [15:0] d;
	logic [15:0] mode0_ff, nxt_mode0, mode2_ff, nxt_mode2, ch0_ff, nxt_ch0;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////////////////////
	assign taken = dev_wr_valid && dev_wr_ready;
	assign a = dev_wr.addr;
	assign d = dev_wr.data;
	always_comb begin
		nxt_mode0 = (taken && a == 8'h10) ? d : mode0_ff;
		nxt_mode2 = (taken && a == 8'h12) ? d : mode2_ff;
		nxt_ch0 = (taken && a == 8'h20) ? d : ch0_ff;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode0_ff <= 16'hffff;
			mode2_ff <= 16'hffff;
			ch0_ff <= 16'h0000;
		end else begin
			mode0_ff <= nxt_mode0;
			mode2_ff <= nxt_mode2;
			ch0_ff <= nxt_ch0;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_bus_okay; hreadyout && !hresp; endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");
	property p_hold; dev_wr_valid && !dev_wr_ready |=> dev_wr_valid && $stable(dev_wr); endproperty
	a_hold: assert property (p_hold) else $error("device write dropped or changed");
	property p_gap; taken |=> !dev_wr_valid; endproperty
	a_gap: assert property (p_gap) else $error("device write without idle cycle");
	property p_start; taken && a == 8'h20 && mode0_ff == 16'h2 && ch0_ff[3] && !d[3]
		|-> ch0_ff[4] && d[4]; endproperty
	a_start: assert property (p_start) else $error("start with clock level low");
	property p_stop; taken && a == 8'h20 && mode0_ff == 16'h2 && !ch0_ff[3] && d[3]
		|-> ch0_ff[4] && d[4]; endproperty
	a_stop: assert property (p_stop) else $error("stop with clock level low");
	property p_addr; taken && a == 8'h20 && mode0_ff == 16'h2 && d[0] |-> !d[1] && d[2]; endproperty
	a_addr: assert property (p_addr) else $error("address send enables wrong");
	property p_ctx; taken && a == 8'h22 |-> d[0] && !d[1] && mode2_ff == 16'h1; endproperty
	a_ctx: assert property (p_ctx) else $error("channel 2 transmit setup wrong");
	property p_crx; taken && a == 8'h23 && d[1] |-> mode2_ff == 16'h1; endproperty
	a_crx: assert property (p_crx) else $error("channel 3 receive without channel 2 mode");
	property p_brx; taken && a == 8'h21 && d[1] |-> mode0_ff == 16'h1; endproperty
	a_brx: assert property (p_brx) else $error("channel 1 receive without async ch0");
	property p_sync; taken && a == 8'h02 && d[0] && mode0_ff != 16'h1 |-> !d[1]; endproperty
	a_sync: assert property (p_sync) else $error("channel 1 started beside sync ch0");
	property p_cgo; taken && a == 8'h02 && d[3] |-> d[2] && mode2_ff == 16'h1; endproperty
	a_cgo: assert property (p_cgo) else $error("channel 3 started alone");
	cover property (dev_wr_valid && !dev_wr_ready);
	cover property (taken && a == 8'h20 && ch0_ff[3] && !d[3]);
	cover property (taken && a == 8'h02 && d[3]);
endmodule // serial_pin_setup_checker

bind serial_pin_setup_host serial_pin_setup_checker #(.MAX_STEPS(MAX_STEPS)) chk_u (
	.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
	.dev_wr_valid(dev_wr_valid), .dev_wr(dev_wr), .dev_wr_ready(dev_wr_ready));

// *** tb/serial_unit_model.sv ***
// Behavioural model of the serial unit behind the setup controller.
// Assumes the controller's write port; slow makes each write wait two cycles.
`timescale 1ns/1ps
module serial_unit_model (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Answer speed.
	input wire logic slow,
	// Register write port.
	input wire logic dev_wr_valid,
	input wire pinroute_pkg::dev_wr_t dev_wr,
	output logic dev_wr_ready,
	// Channel state and pin use.
	output logic [3:0] unit_channel_enable_status,
	output logic [4:0] pin_serial
);
	logic [15:0] mode_ff [4];
	logic [15:0] ch0_ff;
	logic [3:0] en_ff;
	logic [1:0] wait_ff;
	////////////////////////////////////////////////////////////////////////////////
	assign dev_wr_ready = dev_wr_valid && (!slow || wait_ff == 2'h2);
	assign unit_channel_enable_status = en_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_ff <= 2'h0;
			en_ff <= 4'h0;
			ch0_ff <= 16'h0000;
			mode_ff <= '{default: 16'h0000};
		end else begin
			wait_ff <= (dev_wr_valid && !dev_wr_ready) ? wait_ff + 2'h1 : 2'h0;
			if (dev_wr_valid && dev_wr_ready) begin
				if (dev_wr.addr == 8'h01) en_ff <= en_ff & ~dev_wr.data[3:0];
				if (dev_wr.addr == 8'h02) en_ff <= en_ff | dev_wr.data[3:0];
				if (dev_wr.addr[7:4] == 4'h1) mode_ff[dev_wr.addr[1:0]] <= dev_wr.data;
				if (dev_wr.addr == 8'h20) ch0_ff <= dev_wr.data;
			end
		end
	end
	// A pin leaves port use only while its channel runs in a matching mode.
	assign pin_serial[0] = en_ff[0] && mode_ff[0] != 16'h1;
	assign pin_serial[1] = (en_ff[0] && mode_ff[0] != 16'h1)
		|| (en_ff[1] && mode_ff[1] == 16'h1);
	assign pin_serial[2] = en_ff[0] && mode_ff[0] != 16'h2 && ch0_ff[0];
	assign pin_serial[3] = en_ff[2] && mode_ff[2] == 16'h1;
	assign pin_serial[4] = en_ff[3] && mode_ff[3] == 16'h1;
endmodule // serial_unit_model

// *** tb/serial_pin_routing_tb.sv ***
// Self-checking bench for the serial pin setup controller.
// Assumes the controller is the one slave on its bus and the model is its device.
`timescale 1ns/1ps
module serial_pin_setup_host_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic slow = 1'b0;
	logic hreadyout, hresp, dev_wr_valid, dev_wr_ready;
	logic [31:0] hrdata;
	logic [31:0] r;
	logic [3:0] en;
	pinroute_pkg::dev_wr_t dev_wr;
	pinroute_pkg::dev_wr_t log_q [$];
	int failures = 0;
	int checks_done = 0;
	logic [23:0] seq [37] = '{24'h01_0003, 24'h10_0000, 24'h20_001f, 24'h30_001a, 24'h31_0005,
		24'h02_0001, 24'h01_0003, 24'h10_0001, 24'h11_0001, 24'h20_001d, 24'h21_0002,
		24'h30_001a, 24'h31_0005, 24'h02_0003, 24'h01_0003, 24'h10_0002, 24'h30_0018,
		24'h31_0007, 24'h20_0018, 24'h20_0010, 24'h10_0002, 24'h30_0018, 24'h31_0007,
		24'h20_0015, 24'h02_0001, 24'h01_0001, 24'h20_0010, 24'h20_0018, 24'h01_000c,
		24'h12_0001, 24'h13_0001, 24'h22_000d, 24'h23_0002, 24'h30_0010, 24'h31_000f,
		24'h02_000c, 24'h01_000f};
	int prof [7] = '{1, 2, 3, 4, 5, 6, 0};
	int off [7] = '{0, 6, 14, 20, 25, 28, 36};
	int cnt [7] = '{6, 8, 6, 5, 3, 8, 1};
	logic [3:0] ens [7] = '{4'h1, 4'h3, 4'h0, 4'h1, 4'h0, 4'hc, 4'h0};
	////////////////////////////////////////////////////////////////////////////////
	serial_pin_setup_host dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dev_wr_valid(dev_wr_valid),
		.dev_wr(dev_wr), .dev_wr_ready(dev_wr_ready), .unit_channel_enable_status(en));
	serial_unit_model dev_u (.hclk(hclk), .hresetn(hresetn), .slow(slow),
		.dev_wr_valid(dev_wr_valid), .dev_wr(dev_wr), .dev_wr_ready(dev_wr_ready),
		.unit_channel_enable_status(en), .pin_serial());
	always #5 hclk = ~hclk;
	always @(posedge hclk) begin
		if (dev_wr_valid === 1'b1 && dev_wr_ready === 1'b1) log_q.push_back(dev_wr);
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (failures == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (hreadyout !== 1'b1) begin
			failures++;
			stop_test();
		end
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask
	task automatic run(input int i, input logic bz);
		int n;
		log_q.delete();
		xfer(1'b1, 32'h0, {23'h0, 1'b1, 4'h0, prof[i][3:0]}, r);
		if (bz) xfer(1'b1, 32'h0, 32'h106, r);
		n = 0;
		do begin
			xfer(1'b0, 32'h4, 32'h0, r);
			n++;
		end while (r[1] !== 1'b1 && n < 200);
		if (r[1] !== 1'b1) begin
			failures++;
			stop_test();
		end
		cmp("status", {24'h0, ens[i], 4'h2}, r);
		cmp("writes", 32'(cnt[i]), 32'(log_q.size()));
		for (int k = 0; k < cnt[i]; k++) cmp("devwr", {8'h0, seq[off[i] + k]}, {8'h0, log_q[k]});
		xfer(1'b1, 32'h4, 32'h6, r);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(1'b0, 32'h0, 32'h0, r);
		cmp("ctrl", 32'h0, r);
		xfer(1'b0, 32'h4, 32'h0, r);
		cmp("status", 32'h0, r);
		xfer(1'b0, 32'h8, 32'h0, r);
		cmp("ports", 32'h0000001f, r);
		xfer(1'b1, 32'h0c, 32'hffffffff, r);
		xfer(1'b0, 32'h0c, 32'h0, r);
		cmp("unmapped", 32'h0, r);
		xfer(1'b1, 32'h0, 32'h107, r);
		xfer(1'b0, 32'h4, 32'h0, r);
		cmp("status", 32'h4, r);
		xfer(1'b1, 32'h4, 32'h4, r);
		xfer(1'b0, 32'h4, 32'h0, r);
		cmp("status", 32'h0, r);
		cmp("writes", 32'h0, 32'(log_q.size()));
		for (int i = 0; i < 7; i++) begin
			slow <= i[0];
			run(i, 1'b0);
		end
		xfer(1'b0, 32'h8, 32'h0, r);
		cmp("ports", 32'h000f0010, r);
		slow <= 1'b1;
		run(4, 1'b1);
		xfer(1'b0, 32'h0, 32'h0, r);
		cmp("ctrl", 32'h5, r & 32'hf);
		stop_test();
	end
endmodule // serial_pin_setup_host_tb
